// >>> hdl/pin_select_consts.svh
// Function
// - port B setting register, 16 bits, read/write
// - port C setting register, 16 bits, read/write
// - 00 peripheral function, 01 general output
// - 10 general input, pull-up on
// - 11 general input, pull-up off
// - each pin steered only by own field
`ifndef PIN_SELECT_CONSTS_SVH
`define PIN_SELECT_CONSTS_SVH

// register offsets on the local register port
`define PORT_B_SELECT_OFFSET 8'h00
`define PORT_C_SELECT_OFFSET 8'h04
`define PIN_LEVEL_OFFSET 8'h08

// field layout: two bits for each pin
`define SETTING_FIELD_W 2
`define PIN_LEVEL_B_LSB 0
`define PIN_LEVEL_C_LSB 8

// reset values of the two setting registers
`define PORT_B_SELECT_RESET 16'h0000
`define PORT_C_SELECT_RESET 16'hF000

// value returned for an unmapped read
`define UNMAPPED_READ_VALUE 16'h0000

`endif

// >>> hdl/pin_select_pkg.sv
package pin_select_pkg;

  // per-pin setting; encodings follow declaration order 00..11
  typedef enum logic [1:0] {
    MODE_PERIPH,
    MODE_GPIO_OUT,
    MODE_IN_PULL_ON,
    MODE_IN_PULL_OFF
  } pin_mode_e;

  // register data word
  typedef logic [15:0] reg_word_t;

endpackage

// >>> hdl/pin_mux_if.sv
`timescale 1ns/1ps
`default_nettype none

// bundle between the register block and one port's pin mux
interface pin_mux_if #(
  parameter int PINS = 8
);
  logic [2*PINS-1:0] setting; // one field per pin
  logic [PINS-1:0] periph_out; // peripheral drive data
  logic [PINS-1:0] periph_oe; // peripheral drive enable
  logic [PINS-1:0] gpio_out; // general output data
  logic [PINS-1:0] pad_in; // synchronised pad level
  logic [PINS-1:0] pad_out; // pad driver data
  logic [PINS-1:0] pad_oe; // pad driver enable
  logic [PINS-1:0] pull_up; // pull-up switch
  logic [PINS-1:0] periph_in; // pad level to peripheral
  logic [PINS-1:0] gpio_in; // pad level to port data

  // register side
  modport ctrl (
    output setting, periph_out, periph_oe, gpio_out, pad_in,
    input pad_out, pad_oe, pull_up, periph_in, gpio_in
  );

  // pin mux side
  modport mux (
    input setting, periph_out, periph_oe, gpio_out, pad_in,
    output pad_out, pad_oe, pull_up, periph_in, gpio_in
  );
endinterface

`default_nettype wire

// >>> hdl/port_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none

// one port's pad steering, all outputs registered
module port_pin_mux #(
  parameter int PINS = 8
)(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  pin_mux_if.mux pm
);
  import pin_select_pkg::*;

  // refuse widths the field packing cannot serve
  if (PINS < 1 || PINS > 8)
  begin : bad_pins
    $error("port_pin_mux: PINS must be 1 to 8");
  end

  // field of pin n sits at bits 2n+1:2n
  function automatic pin_mode_e mode_of(
    input logic [2*PINS-1:0] s,
    input int n
  );
    mode_of = pin_mode_e'(s[2*n +: 2]);
  endfunction

  logic [PINS-1:0] pad_out_q; // driver data
  logic [PINS-1:0] pad_oe_q; // driver enable
  logic [PINS-1:0] pull_up_q; // pull-up switches
  logic [PINS-1:0] periph_in_q; // peripheral input
  logic [PINS-1:0] gpio_in_q; // port input

  // pad drivers: each pin looks only at its own field
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
    end
    else
    begin
      for (int n = 0; n < PINS; n++)
      begin
        case (mode_of(pm.setting, n))
          MODE_PERIPH:
          begin
            pad_out_q[n] <= pm.periph_out[n];
            pad_oe_q[n] <= pm.periph_oe[n];
          end
          MODE_GPIO_OUT:
          begin
            pad_out_q[n] <= pm.gpio_out[n];
            pad_oe_q[n] <= 1'b1;
          end
          default:
          begin
            // input settings never drive the pad
            pad_out_q[n] <= 1'b0;
            pad_oe_q[n] <= 1'b0;
          end
        endcase
      end
    end
  end

  // pull-up only for the pull-on input setting
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      pull_up_q <= '0;
    else
      for (int n = 0; n < PINS; n++)
        pull_up_q[n] <= (mode_of(pm.setting, n) == MODE_IN_PULL_ON);
  end

  // input routing: peripheral sees pad only in peripheral setting
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      periph_in_q <= '0;
      gpio_in_q <= '0;
    end
    else
    begin
      for (int n = 0; n < PINS; n++)
      begin
        periph_in_q[n] <= (mode_of(pm.setting, n) == MODE_PERIPH) &&
                          pm.pad_in[n];
        // output setting reads back what it drives
        gpio_in_q[n] <= (mode_of(pm.setting, n) == MODE_GPIO_OUT) ?
                        pm.gpio_out[n] :
                        (mode_of(pm.setting, n) != MODE_PERIPH) &&
                        pm.pad_in[n];
      end
    end
  end

  assign pm.pad_out = pad_out_q;
  assign pm.pad_oe = pad_oe_q;
  assign pm.pull_up = pull_up_q;
  assign pm.periph_in = periph_in_q;
  assign pm.gpio_in = gpio_in_q;

  // sampled reset gates each antecedent: the release edge still clears
  // the output flops, so sources seen there must not be expected
  for (genvar g = 0; g < PINS; g++)
  begin : pin_chk
    periph_route_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !sys_rst_i && mode_of(pm.setting, g) == MODE_PERIPH |=>
        pm.pad_oe[g] == $past(pm.periph_oe[g]) &&
        pm.pad_out[g] == $past(pm.periph_out[g]))
      else $error("peripheral setting not routed to pad");
    gpio_drive_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !sys_rst_i && mode_of(pm.setting, g) == MODE_GPIO_OUT |=>
        pm.pad_oe[g] && !pm.pull_up[g] &&
        pm.pad_out[g] == $past(pm.gpio_out[g]))
      else $error("output setting not driving pad");
    pull_on_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !sys_rst_i && mode_of(pm.setting, g) == MODE_IN_PULL_ON |=>
        pm.pull_up[g] && !pm.pad_oe[g])
      else $error("pull-on input setting wrong");
    pull_off_a: assert property (
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !sys_rst_i && mode_of(pm.setting, g) == MODE_IN_PULL_OFF |=>
        !pm.pull_up[g] && !pm.pad_oe[g])
      else $error("pull-off input setting wrong");
  end
endmodule

`default_nettype wire

// >>> hdl/port_b_c_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_consts.svh"

// setting registers for ports B and C plus their pad steering
module port_b_c_pin_function_select #(
  parameter int ADDR_W = 8,
  parameter int PINS = 8
)(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire pin_select_pkg::reg_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output pin_select_pkg::reg_word_t reg_rdata_o,
  // port B pads and sources
  input wire logic [PINS-1:0] port_b_pad_in_i,
  output logic [PINS-1:0] port_b_pad_out_o,
  output logic [PINS-1:0] port_b_pad_oe_o,
  output logic [PINS-1:0] port_b_pull_up_o,
  input wire logic [PINS-1:0] port_b_periph_out_i,
  input wire logic [PINS-1:0] port_b_periph_oe_i,
  output logic [PINS-1:0] port_b_periph_in_o,
  input wire logic [PINS-1:0] port_b_gpio_out_i,
  output logic [PINS-1:0] port_b_gpio_in_o,
  // port C pads and sources
  input wire logic [PINS-1:0] port_c_pad_in_i,
  output logic [PINS-1:0] port_c_pad_out_o,
  output logic [PINS-1:0] port_c_pad_oe_o,
  output logic [PINS-1:0] port_c_pull_up_o,
  input wire logic [PINS-1:0] port_c_periph_out_i,
  input wire logic [PINS-1:0] port_c_periph_oe_i,
  output logic [PINS-1:0] port_c_periph_in_o,
  input wire logic [PINS-1:0] port_c_gpio_out_i,
  output logic [PINS-1:0] port_c_gpio_in_o
);
  import pin_select_pkg::*;

  // the setting registers are exactly two bits per pin of 16
  if (PINS != 8)
  begin : bad_pins
    $error("pin select: PINS must be 8 for 16-bit registers");
  end

  // offsets are 8 bits wide, so the address must hold them
  if (ADDR_W < 8 || ADDR_W > 16)
  begin : bad_addr
    $error("pin select: ADDR_W must be 8 to 16");
  end

  // true when the address names the given offset
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] off
  );
    addr_hit = (a == ADDR_W'(off));
  endfunction

  // setting registers
  reg_word_t port_b_function_select_q; // port B fields
  reg_word_t port_c_function_select_q; // port C fields
  reg_word_t reg_rdata_q; // read data, valid one cycle after strobe

  // pad input synchronisers: first stage feeds only the second
  logic [PINS-1:0] port_b_meta_q; // first stage, port B
  logic [PINS-1:0] port_b_sync_q; // second stage, port B
  logic [PINS-1:0] port_c_meta_q; // first stage, port C
  logic [PINS-1:0] port_c_sync_q; // second stage, port C

  // write decode, shared by both registers
  logic wr_port_b; // write to port B register
  logic wr_port_c; // write to port C register

  assign wr_port_b = reg_wr_i &&
                     addr_hit(reg_addr_i, `PORT_B_SELECT_OFFSET);
  assign wr_port_c = reg_wr_i &&
                     addr_hit(reg_addr_i, `PORT_C_SELECT_OFFSET);

  // port B setting register: all 16 bits writable
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      port_b_function_select_q <= `PORT_B_SELECT_RESET;
    else if (wr_port_b)
      port_b_function_select_q <= reg_wdata_i;
  end

  // port C setting register: pins 7 and 6 come up as plain inputs
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      port_c_function_select_q <= `PORT_C_SELECT_RESET;
    else if (wr_port_c)
      port_c_function_select_q <= reg_wdata_i;
  end

  // two-stage synchronisers for the asynchronous pad levels
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      port_b_meta_q <= '0;
      port_b_sync_q <= '0;
      port_c_meta_q <= '0;
      port_c_sync_q <= '0;
    end
    else
    begin
      port_b_meta_q <= port_b_pad_in_i;
      port_b_sync_q <= port_b_meta_q;
      port_c_meta_q <= port_c_pad_in_i;
      port_c_sync_q <= port_c_meta_q;
    end
  end

  // read data: registered, so it stands only in the cycle after rd
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_q <= `UNMAPPED_READ_VALUE;
    else if (reg_rd_i)
    begin
      if (addr_hit(reg_addr_i, `PORT_B_SELECT_OFFSET))
        reg_rdata_q <= port_b_function_select_q;
      else if (addr_hit(reg_addr_i, `PORT_C_SELECT_OFFSET))
        reg_rdata_q <= port_c_function_select_q;
      else if (addr_hit(reg_addr_i, `PIN_LEVEL_OFFSET))
      begin
        // live synchronised pad levels, read only
        reg_rdata_q <= `UNMAPPED_READ_VALUE;
        reg_rdata_q[`PIN_LEVEL_B_LSB +: PINS] <= port_b_sync_q;
        reg_rdata_q[`PIN_LEVEL_C_LSB +: PINS] <= port_c_sync_q;
      end
      else
        // unmapped offsets read as zero, writes there are dropped
        reg_rdata_q <= `UNMAPPED_READ_VALUE;
    end
    else
      // data only valid in the cycle after the strobe
      reg_rdata_q <= `UNMAPPED_READ_VALUE;
  end

  assign reg_rdata_o = reg_rdata_q;

  // one carrier bundle per port
  pin_mux_if #(.PINS(PINS)) port_b_bus ();
  pin_mux_if #(.PINS(PINS)) port_c_bus ();

  // port B: register fields and sources into the mux
  assign port_b_bus.setting = port_b_function_select_q;
  assign port_b_bus.periph_out = port_b_periph_out_i;
  assign port_b_bus.periph_oe = port_b_periph_oe_i;
  assign port_b_bus.gpio_out = port_b_gpio_out_i;
  assign port_b_bus.pad_in = port_b_sync_q;

  // port C: same wiring on its own register
  assign port_c_bus.setting = port_c_function_select_q;
  assign port_c_bus.periph_out = port_c_periph_out_i;
  assign port_c_bus.periph_oe = port_c_periph_oe_i;
  assign port_c_bus.gpio_out = port_c_gpio_out_i;
  assign port_c_bus.pad_in = port_c_sync_q;

  // pad steering for port B
  port_pin_mux #(
    .PINS(PINS)
  ) port_b_mux (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .pm(port_b_bus)
  );

  // pad steering for port C
  port_pin_mux #(
    .PINS(PINS)
  ) port_c_mux (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .pm(port_c_bus)
  );

  // registered mux outputs straight to the pads, the peripheral inputs and the port data inputs
  assign port_b_pad_out_o = port_b_bus.pad_out;
  assign port_b_pad_oe_o = port_b_bus.pad_oe;
  assign port_b_pull_up_o = port_b_bus.pull_up;
  assign port_b_periph_in_o = port_b_bus.periph_in;
  assign port_b_gpio_in_o = port_b_bus.gpio_in;
  assign port_c_pad_out_o = port_c_bus.pad_out;
  assign port_c_pad_oe_o = port_c_bus.pad_oe;
  assign port_c_pull_up_o = port_c_bus.pull_up;
  assign port_c_periph_in_o = port_c_bus.periph_in;
  assign port_c_gpio_in_o = port_c_bus.gpio_in;

  // write lands in port B register the next cycle
  port_b_write_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_port_b |=> port_b_function_select_q == $past(reg_wdata_i))
    else $error("port B register did not take write");

  // write lands in port C register the next cycle
  port_c_write_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_port_c |=> port_c_function_select_q == $past(reg_wdata_i))
    else $error("port C register did not take write");

  // port B read returns the held value one cycle later
  port_b_read_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_rd_i && addr_hit(reg_addr_i, `PORT_B_SELECT_OFFSET) |=>
      reg_rdata_o == $past(port_b_function_select_q))
    else $error("port B readback wrong");

  // port C read returns the held value one cycle later
  port_c_read_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_rd_i && addr_hit(reg_addr_i, `PORT_C_SELECT_OFFSET) |=>
      reg_rdata_o == $past(port_c_function_select_q))
    else $error("port C readback wrong");

  // registers hold without a write to them
  setting_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !reg_wr_i |=> $stable(port_b_function_select_q) &&
      $stable(port_c_function_select_q))
    else $error("setting register changed without write");

  // reset values right after release
  reset_value_a: assert property (
    @(posedge sys_clk_i)
    $past(sys_rst_i) |->
      port_b_function_select_q == `PORT_B_SELECT_RESET &&
      port_c_function_select_q == `PORT_C_SELECT_RESET)
    else $error("setting register reset value wrong");

  // port C pins 7 and 6 settle as undriven, pull-off inputs
  reset_pins_a: assert property (
    @(posedge sys_clk_i)
    $past(sys_rst_i) && !sys_rst_i && !reg_wr_i |=>
      !port_c_pull_up_o[7] && !port_c_pad_oe_o[7] &&
      !port_c_pull_up_o[6] && !port_c_pad_oe_o[6])
    else $error("port C upper pins not plain inputs after reset");

  // a port C write never disturbs port B pins
  pin_isolate_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_port_c ##1 !reg_wr_i |=>
      $stable(port_b_pull_up_o))
    else $error("port C write disturbed port B pull-ups");

  // read data stands for one cycle only
  read_pulse_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !reg_rd_i |=> reg_rdata_o == `UNMAPPED_READ_VALUE)
    else $error("read data stood past its cycle");

  // level register returns both synchronised pad sets
  level_read_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_rd_i && addr_hit(reg_addr_i, `PIN_LEVEL_OFFSET) |=>
      reg_rdata_o == {$past(port_c_sync_q), $past(port_b_sync_q)})
    else $error("pin level readback wrong");

  // unmapped offsets read as zero
  unmapped_read_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_rd_i && !addr_hit(reg_addr_i, `PORT_B_SELECT_OFFSET) &&
      !addr_hit(reg_addr_i, `PORT_C_SELECT_OFFSET) &&
      !addr_hit(reg_addr_i, `PIN_LEVEL_OFFSET) |=>
      reg_rdata_o == `UNMAPPED_READ_VALUE)
    else $error("unmapped read not zero");

  // writes elsewhere leave both setting registers alone
  stray_write_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_wr_i && !wr_port_b && !wr_port_c |=>
      $stable(port_b_function_select_q) &&
      $stable(port_c_function_select_q))
    else $error("stray write changed a setting register");

  // a port B write never disturbs port C pins
  port_c_isolate_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_port_b ##1 !reg_wr_i |=>
      $stable(port_c_pull_up_o))
    else $error("port B write disturbed port C pull-ups");

  // outputs held quiet while reset stands
  reset_quiet_a: assert property (
    @(posedge sys_clk_i)
    sys_rst_i |=>
      port_b_pad_oe_o == '0 && port_b_pull_up_o == '0 &&
      port_c_pad_oe_o == '0 && port_c_pull_up_o == '0 &&
      reg_rdata_o == `UNMAPPED_READ_VALUE)
    else $error("outputs active during reset");

  // port B and low port C pins come up with pull-ups off
  reset_pull_a: assert property (
    @(posedge sys_clk_i)
    $past(sys_rst_i) && !sys_rst_i && !reg_wr_i |=>
      port_b_pull_up_o == '0 && port_c_pull_up_o[5:0] == '0)
    else $error("pull-up on after reset");
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_consts.svh"

// bench for the port b/c pin setting block, no partner model
module tb_top;
  import pin_select_pkg::*;

  logic sys_clk; // 200 mhz system clock
  logic sys_rst; // synchronous reset, active high
  logic [7:0] addr; // register byte address
  reg_word_t wdata; // register write data
  logic wr; // write strobe
  logic rd; // read strobe
  reg_word_t rdata; // read data, one cycle after rd
  logic [7:0] b_pad_in, b_pad_out, b_pad_oe, b_pull, b_pout, b_poe;
  logic [7:0] b_pin, b_gout, b_gin;
  logic [7:0] c_pad_in, c_pad_out, c_pad_oe, c_pull, c_pout, c_poe;
  logic [7:0] c_pin, c_gout, c_gin;
  int n_fail; // mismatches seen
  int total_checks; // comparisons made
  reg_word_t sb_q; // last port b setting written
  reg_word_t sc_q; // last port c setting written

  port_b_c_pin_function_select #(.ADDR_W(8), .PINS(8))
    port_b_c_pin_function_select_inst (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata),
    .port_b_pad_in_i(b_pad_in), .port_b_pad_out_o(b_pad_out),
    .port_b_pad_oe_o(b_pad_oe), .port_b_pull_up_o(b_pull),
    .port_b_periph_out_i(b_pout), .port_b_periph_oe_i(b_poe),
    .port_b_periph_in_o(b_pin), .port_b_gpio_out_i(b_gout),
    .port_b_gpio_in_o(b_gin),
    .port_c_pad_in_i(c_pad_in), .port_c_pad_out_o(c_pad_out),
    .port_c_pad_oe_o(c_pad_oe), .port_c_pull_up_o(c_pull),
    .port_c_periph_out_i(c_pout), .port_c_periph_oe_i(c_poe),
    .port_c_periph_in_o(c_pin), .port_c_gpio_out_i(c_gout),
    .port_c_gpio_in_o(c_gin)
  );

  // clock, 5 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // verdict and end of run, the single exit point
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // register word comparison
  task automatic cmp16(input reg_word_t got, input reg_word_t exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // pin vector comparison: oe, out, pull, periph_in, gpio_in
  task automatic cmp40(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected pins at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write, strobe dropped at the next edge
  task automatic reg_write(input logic [7:0] a, input reg_word_t d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // one-cycle read, data taken in the following cycle only
  task automatic reg_read(input logic [7:0] a, output reg_word_t d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // expected pin outputs of one port; pad_out only counts when driven
  function automatic logic [39:0] pin_exp(input reg_word_t s,
    input logic [7:0] po, input logic [7:0] oe, input logic [7:0] go,
    input logic [7:0] pad);
    logic [7:0] e_oe, e_out, e_pu, e_pi, e_gi;
    e_oe = '0;
    e_out = '0;
    e_pu = '0;
    e_pi = '0;
    e_gi = '0;
    for (int n = 0; n < 8; n++)
    begin
      case (s[2*n+:2])
        MODE_PERIPH:
        begin
          e_oe[n] = oe[n];
          e_out[n] = po[n];
          e_pi[n] = pad[n];
        end
        MODE_GPIO_OUT:
        begin
          e_oe[n] = 1'b1;
          e_out[n] = go[n];
          e_gi[n] = go[n];
        end
        MODE_IN_PULL_ON:
        begin
          e_pu[n] = 1'b1;
          e_gi[n] = pad[n];
        end
        default:
          e_gi[n] = pad[n];
      endcase
    end
    return {e_oe, e_out & e_oe, e_pu, e_pi, e_gi};
  endfunction

  // new source pattern, then wait out pad synchroniser and output flops
  task automatic set_sources(input logic [7:0] k);
    @(posedge sys_clk);
    b_pout <= k;
    b_poe <= k ^ 8'h0f;
    b_gout <= ~k;
    b_pad_in <= k ^ 8'h3c;
    c_pout <= ~k;
    c_poe <= k ^ 8'hf0;
    c_gout <= k ^ 8'h55;
    c_pad_in <= k ^ 8'hc3;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  // compare both ports against the settings held in sb_q and sc_q
  task automatic check_pins();
    logic [39:0] eb, ec;
    eb = pin_exp(sb_q, b_pout, b_poe, b_gout, b_pad_in);
    ec = pin_exp(sc_q, c_pout, c_poe, c_gout, c_pad_in);
    cmp40({b_pad_oe, b_pad_out & eb[39:32], b_pull, b_pin, b_gin}, eb);
    cmp40({c_pad_oe, c_pad_out & ec[39:32], c_pull, c_pin, c_gin}, ec);
  endtask

  // synchronous reset pulse of three cycles
  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask

  // reset values read back and shown on the pads
  task automatic test_reset_values();
    reg_word_t d;
    reg_read(`PORT_B_SELECT_OFFSET, d);
    cmp16(d, 16'h0000);
    reg_read(`PORT_C_SELECT_OFFSET, d);
    cmp16(d, 16'hf000);
    sb_q = 16'h0000;
    sc_q = 16'hf000;
    set_sources(8'h96);
    check_pins();
  endtask

  // every bit of both registers written and read as 0 and 1
  task automatic test_readback();
    reg_word_t d;
    reg_word_t pat [2] = '{16'ha5c3, 16'h5a3c};
    foreach (pat[i])
    begin
      reg_write(`PORT_B_SELECT_OFFSET, pat[i]);
      reg_write(`PORT_C_SELECT_OFFSET, ~pat[i]);
      reg_read(`PORT_B_SELECT_OFFSET, d);
      cmp16(d, pat[i]);
      reg_read(`PORT_C_SELECT_OFFSET, d);
      cmp16(d, ~pat[i]);
    end
    sb_q = 16'h5a3c;
    sc_q = 16'ha5c3;
  endtask

  // unmapped and read-only places leave the settings alone
  task automatic test_unmapped();
    reg_word_t d;
    reg_write(8'h10, 16'hffff);
    reg_write(`PIN_LEVEL_OFFSET, 16'hffff);
    reg_read(`PORT_B_SELECT_OFFSET, d);
    cmp16(d, sb_q);
    reg_read(`PORT_C_SELECT_OFFSET, d);
    cmp16(d, sc_q);
    reg_read(8'h10, d);
    cmp16(d, `UNMAPPED_READ_VALUE);
    reg_read(`PIN_LEVEL_OFFSET, d);
    cmp16(d, {c_pad_in, b_pad_in});
    // read data stands for one cycle only
    @(posedge sys_clk);
    #1;
    cmp16(rdata, 16'h0000);
  endtask

  // every mode on every pin, each port on its own, two source sets
  task automatic test_modes();
    reg_word_t sv [4] = '{16'he4e4, 16'h1b1b, 16'h4eb1, 16'hb14e};
    foreach (sv[i])
    begin
      sb_q = sv[i];
      sc_q = sv[3-i];
      reg_write(`PORT_B_SELECT_OFFSET, sb_q);
      reg_write(`PORT_C_SELECT_OFFSET, sc_q);
      set_sources(8'h5a + 8'(i));
      check_pins();
      set_sources(8'ha5 - 8'(i));
      check_pins();
    end
  endtask

  // reset in mid-run brings back the initial settings
  task automatic test_second_reset();
    do_reset();
    test_reset_values();
  endtask

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    {b_pad_in, b_pout, b_poe, b_gout} = '0;
    {c_pad_in, c_pout, c_poe, c_gout} = '0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_reset_values();
    test_readback();
    test_unmapped();
    test_modes();
    test_second_reset();
    print_verdict();
  end
endmodule

`default_nettype wire
